// >>> xlau_unit.sv
/*
 * Exclusive-OR logic and accumulate unit with its own data register file.
 * Assumes the decoder issues one operation at a time and waits for op_ready.
 */
// Notes on behaviour
// - Bitwise XNOR writes inverted XOR result.
// - Bitwise forms zero-extend the nine-bit immediate.
// - Three-operand XOR writes the separate destination.
// - Short XOR writes back into first source.
// - Bit XNOR: inverted bit XOR, upper bits cleared.
// - Bit XOR into bit 0, rest zero.
// - Accumulating compares keep destination bits 31:1.
// - Equal compare toggles bit 0 on match.
// - Unequal compare toggles bit 0 on mismatch.
// - Signed compares sign-extend the immediate.
// - Signed greater-or-equal toggles bit 0.
// - Unsigned greater-or-equal zero-extends, toggles bit 0.
// - Signed less-than toggles bit 0.
// - Unsigned less-than is unsigned, zero-extends immediate.
`timescale 1ns/1ps
module xlau_unit (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// Handshake with the decoder
	input  wire logic                          op_valid,
	output logic                               op_ready,
	// Operation and immediate
	input  wire xlau_pkg::xlau_op_t            op_code,
	input  wire logic                          use_immediate,
	input  wire logic [xlau_pkg::IMM_W-1:0]    nine_bit_immediate,
	// Register indices
	input  wire logic [xlau_pkg::ADDR_W-1:0]   first_source_reg,
	input  wire logic [xlau_pkg::ADDR_W-1:0]   second_source_reg,
	input  wire logic [xlau_pkg::ADDR_W-1:0]   destination_reg,
	// Bit positions for the single-bit forms
	input  wire logic [xlau_pkg::SEL_W-1:0]    first_bit_select,
	input  wire logic [xlau_pkg::SEL_W-1:0]    second_bit_select,
	// Status flags, one flop late and never modified
	input  wire logic [4:0]                    status_flags_in,
	output logic      [4:0]                    status_flags_out,
	// Result and completion
	output logic                               result_valid,
	output logic      [xlau_pkg::ADDR_W-1:0]   result_reg,
	output logic      [xlau_pkg::DATA_W-1:0]   result_data
);
	// ****************************************
	// Sequencer
	// ****************************************
	typedef enum logic [1:0] {
		XLAU_IDLE,
		XLAU_READ,
		XLAU_EXEC
	} xlau_state_t;

	xlau_state_t                   state_r;
	xlau_state_t                   state_nxt;
	xlau_pkg::xlau_op_t            op_r;
	logic                          imm_sel_r;
	logic [xlau_pkg::IMM_W-1:0]    imm_r;
	logic [xlau_pkg::ADDR_W-1:0]   src_a_r;
	logic [xlau_pkg::ADDR_W-1:0]   src_b_r;
	logic [xlau_pkg::ADDR_W-1:0]   dst_r;
	logic [xlau_pkg::SEL_W-1:0]    sel_a_r;
	logic [xlau_pkg::SEL_W-1:0]    sel_b_r;
	logic [xlau_pkg::DATA_W-1:0]   rd_a_data;
	logic [xlau_pkg::DATA_W-1:0]   rd_b_data;
	logic [xlau_pkg::DATA_W-1:0]   rd_c_data;
	logic                          wr_en;
	logic [xlau_pkg::ADDR_W-1:0]   wr_addr;
	logic [xlau_pkg::DATA_W-1:0]   wr_data;
	logic [xlau_pkg::ADDR_W-1:0]   eff_dst;
	logic                          take;

	assign op_ready = (state_r == XLAU_IDLE);
	// A request is taken only while idle; otherwise the decoder must hold it
	assign take     = op_valid && op_ready;

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			XLAU_IDLE: begin
				if (op_valid) begin
					state_nxt = XLAU_READ;
				end
			end
			XLAU_READ: begin
				state_nxt = XLAU_EXEC;
			end
			XLAU_EXEC: begin
				state_nxt = XLAU_IDLE;
			end
			default: begin
				state_nxt = XLAU_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= XLAU_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// Capture of the decoded operation
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_r      <= xlau_pkg::XLAU_OP_XOR;
			imm_sel_r <= 1'b0;
			imm_r     <= 9'h000;
		end else if (take) begin
			op_r      <= op_code;
			imm_sel_r <= use_immediate;
			imm_r     <= nine_bit_immediate;
		end
	end

	// Register indices; these drive the register file read addresses directly
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			src_a_r <= 4'h0;
			src_b_r <= 4'h0;
			dst_r   <= 4'h0;
		end else if (take) begin
			src_a_r <= first_source_reg;
			src_b_r <= second_source_reg;
			dst_r   <= destination_reg;
		end
	end

	// Bit positions for the single-bit forms
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_a_r <= 5'h00;
			sel_b_r <= 5'h00;
		end else if (take) begin
			sel_a_r <= first_bit_select;
			sel_b_r <= second_bit_select;
		end
	end

	// ****************************************
	// Operands
	// ****************************************
	logic [xlau_pkg::DATA_W-1:0] imm_zext;
	logic [xlau_pkg::DATA_W-1:0] imm_sext;
	logic [xlau_pkg::DATA_W-1:0] opnd_logic;
	logic [xlau_pkg::DATA_W-1:0] opnd_signed;
	logic [xlau_pkg::DATA_W-1:0] opnd_unsigned;
	logic                        bit_a;
	logic                        bit_b;
	logic                        cmp_hit;
	logic                        same_val;
	logic                        below_signed;
	logic                        below_unsigned;

	assign imm_zext = {{(xlau_pkg::DATA_W-xlau_pkg::IMM_W){1'b0}}, imm_r};
	assign imm_sext = {{(xlau_pkg::DATA_W-xlau_pkg::IMM_W){imm_r[xlau_pkg::IMM_SIGN]}},
		imm_r};
	assign opnd_logic    = imm_sel_r ? imm_zext : rd_b_data;
	assign opnd_signed   = imm_sel_r ? imm_sext : rd_b_data;
	assign opnd_unsigned = imm_sel_r ? imm_zext : rd_b_data;
	assign bit_a = rd_a_data[sel_a_r];
	assign bit_b = rd_b_data[sel_b_r];

	// Greater-or-equal reuses the less-than compares, saving two wide comparators
	assign same_val       = (rd_a_data == opnd_signed);
	assign below_signed   = ($signed(rd_a_data) < $signed(opnd_signed));
	assign below_unsigned = (rd_a_data < opnd_unsigned);

	// ****************************************
	// Compare for the accumulating forms
	// ****************************************
	always_comb begin
		cmp_hit = 1'b0;
		unique case (op_r)
			xlau_pkg::XLAU_OP_ACC_EQ: begin
				cmp_hit = same_val;
			end
			xlau_pkg::XLAU_OP_ACC_NE: begin
				cmp_hit = !same_val;
			end
			xlau_pkg::XLAU_OP_ACC_GE: begin
				cmp_hit = !below_signed;
			end
			xlau_pkg::XLAU_OP_ACC_GE_U: begin
				cmp_hit = !below_unsigned;
			end
			xlau_pkg::XLAU_OP_ACC_LT: begin
				cmp_hit = below_signed;
			end
			xlau_pkg::XLAU_OP_ACC_LT_U: begin
				// Unsigned, whatever the prose around it suggests
				cmp_hit = below_unsigned;
			end
			default: begin
				cmp_hit = 1'b0;
			end
		endcase
	end

	// ****************************************
	// Result
	// ****************************************
	always_comb begin
		wr_data = rd_c_data;
		eff_dst = dst_r;
		unique case (op_r)
			xlau_pkg::XLAU_OP_XOR: begin
				wr_data = rd_a_data ^ opnd_logic;
			end
			xlau_pkg::XLAU_OP_XNOR: begin
				wr_data = ~(rd_a_data ^ opnd_logic);
			end
			xlau_pkg::XLAU_OP_XOR_SHORT: begin
				wr_data = rd_a_data ^ rd_b_data;
				eff_dst = src_a_r;
			end
			xlau_pkg::XLAU_OP_BIT_XOR: begin
				wr_data = {31'h0000_0000, bit_a ^ bit_b};
			end
			xlau_pkg::XLAU_OP_BIT_XNOR: begin
				wr_data = {31'h0000_0000, ~(bit_a ^ bit_b)};
			end
			xlau_pkg::XLAU_OP_ACC_EQ,
			xlau_pkg::XLAU_OP_ACC_NE,
			xlau_pkg::XLAU_OP_ACC_GE,
			xlau_pkg::XLAU_OP_ACC_GE_U,
			xlau_pkg::XLAU_OP_ACC_LT,
			xlau_pkg::XLAU_OP_ACC_LT_U: begin
				// Only the accumulate bit moves; the old upper bits go back unchanged
				wr_data = {rd_c_data[xlau_pkg::DATA_W-1:1],
					rd_c_data[xlau_pkg::ACC_BIT] ^ cmp_hit};
			end
			default: begin
				// Unused codes rewrite the destination with its own value
				wr_data = rd_c_data;
			end
		endcase
	end

	// ****************************************
	// Write-back
	// ****************************************
	// One write per operation, after all three reads were taken
	assign wr_en   = (state_r == XLAU_EXEC);
	assign wr_addr = eff_dst;

	// ****************************************
	// Status flags
	// ****************************************
	// Registered like every data output; no operation has a path into them
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			status_flags_out <= 5'h00;
		end else begin
			status_flags_out <= status_flags_in;
		end
	end

	// ****************************************
	// Completion
	// ****************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_valid <= 1'b0;
		end else begin
			result_valid <= wr_en;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			result_reg  <= 4'h0;
			result_data <= xlau_pkg::REG_RESET;
		end else if (wr_en) begin
			result_reg  <= wr_addr;
			result_data <= wr_data;
		end
	end

	// ****************************************
	// Register file
	// ****************************************
	// The destination is read too, so the accumulate forms see its pre-operation value
	xlau_regfile u_regfile (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.rd_a_addr (src_a_r),
		.rd_b_addr (src_b_r),
		.rd_c_addr (dst_r),
		.rd_a_data (rd_a_data),
		.rd_b_data (rd_b_data),
		.rd_c_data (rd_c_data),
		.wr_en     (wr_en),
		.wr_addr   (wr_addr),
		.wr_data   (wr_data)
	);
endmodule

// >>> xlau_pkg.sv
/*
 * Package for the exclusive-OR logic and accumulate unit: widths, operation codes, field layout.
 * Assumes the decoder and register file run on the same core clock as the unit.
 */
package xlau_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int DATA_W   = 32;
	localparam int IMM_W    = 9;
	localparam int SEL_W    = 5;
	localparam int REG_N    = 16;
	localparam int ADDR_W   = 4;
	localparam int ACC_BIT  = 0;
	localparam int IMM_SIGN = 8;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [31:0] REG_RESET = 32'h0000_0000;

	// ****************************************
	// Operations
	// ****************************************
	typedef enum logic [3:0] {
		XLAU_OP_XOR,
		XLAU_OP_XNOR,
		XLAU_OP_XOR_SHORT,
		XLAU_OP_BIT_XOR,
		XLAU_OP_BIT_XNOR,
		XLAU_OP_ACC_EQ,
		XLAU_OP_ACC_NE,
		XLAU_OP_ACC_GE,
		XLAU_OP_ACC_GE_U,
		XLAU_OP_ACC_LT,
		XLAU_OP_ACC_LT_U
	} xlau_op_t;
endpackage

// >>> xlau_regfile.sv
/*
 * Data register file: sixteen 32-bit words, three read ports, one write port.
 * Assumes the caller presents read addresses one cycle before it needs the data.
 */
`timescale 1ns/1ps
module xlau_regfile (
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// Read ports
	input  wire logic [xlau_pkg::ADDR_W-1:0]   rd_a_addr,
	input  wire logic [xlau_pkg::ADDR_W-1:0]   rd_b_addr,
	input  wire logic [xlau_pkg::ADDR_W-1:0]   rd_c_addr,
	output logic      [xlau_pkg::DATA_W-1:0]   rd_a_data,
	output logic      [xlau_pkg::DATA_W-1:0]   rd_b_data,
	output logic      [xlau_pkg::DATA_W-1:0]   rd_c_data,
	// Write port
	input  wire logic                          wr_en,
	input  wire logic [xlau_pkg::ADDR_W-1:0]   wr_addr,
	input  wire logic [xlau_pkg::DATA_W-1:0]   wr_data
);
	logic [xlau_pkg::DATA_W-1:0] mem_r [xlau_pkg::REG_N];

	// ****************************************
	// Storage
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < xlau_pkg::REG_N; gi++) begin : g_word
			always_ff @(posedge clk or posedge sys_rst) begin
				if (sys_rst) begin
					mem_r[gi] <= xlau_pkg::REG_RESET;
				end else if (wr_en && wr_addr == xlau_pkg::ADDR_W'(gi)) begin
					mem_r[gi] <= wr_data;
				end
			end
		end
	endgenerate

	// Registered read; a same-cycle write is not forwarded here, the caller stalls instead
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_a_data <= xlau_pkg::REG_RESET;
			rd_b_data <= xlau_pkg::REG_RESET;
			rd_c_data <= xlau_pkg::REG_RESET;
		end else begin
			rd_a_data <= mem_r[rd_a_addr];
			rd_b_data <= mem_r[rd_b_addr];
			rd_c_data <= mem_r[rd_c_addr];
		end
	end
endmodule

// >>> xlau_chk.sv
/*
 * Checker for the exclusive-OR logic and accumulate unit: port timing and targets.
 * Assumes it is bound to xlau_unit and sees only its ports.
 */
`timescale 1ns/1ps
module xlau_chk (
	input wire logic               clk,
	input wire logic               sys_rst,
	input wire logic               op_valid,
	input wire logic               op_ready,
	input wire xlau_pkg::xlau_op_t op_code,
	input wire logic [3:0]         first_source_reg,
	input wire logic [3:0]         destination_reg,
	input wire logic [4:0]         status_flags_in,
	input wire logic [4:0]         status_flags_out,
	input wire logic               result_valid,
	input wire logic [3:0]         result_reg,
	input wire logic [31:0]        result_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_answer_time: assert property ((op_valid && op_ready) |-> ##3 result_valid)
		else $error("result not three cycles after request");
	a_ready_busy: assert property ((op_valid && op_ready) |=> !op_ready [*2] ##1 op_ready)
		else $error("ready not low for two cycles");
	a_pulse_once: assert property (result_valid |=> !result_valid)
		else $error("result pulse longer than one cycle");
	a_valid_cause: assert property (result_valid |-> $past(op_valid && op_ready, 3))
		else $error("result without request");
	a_flags_kept: assert property (status_flags_out == $past(status_flags_in))
		else $error("status flags altered");
	a_short_target: assert property ((op_valid && op_ready &&
		op_code == xlau_pkg::XLAU_OP_XOR_SHORT) |-> ##3 result_reg == $past(first_source_reg, 3))
		else $error("short form wrote wrong register");
	a_dest_target: assert property ((op_valid && op_ready &&
		op_code != xlau_pkg::XLAU_OP_XOR_SHORT) |-> ##3 result_reg == $past(destination_reg, 3))
		else $error("result written to wrong register");
	a_bit_upper: assert property ((op_valid && op_ready && op_code inside
		{xlau_pkg::XLAU_OP_BIT_XOR, xlau_pkg::XLAU_OP_BIT_XNOR}) |-> ##3 result_data[31:1] == 31'h0)
		else $error("bit result upper bits not clear");
	a_result_hold: assert property (!result_valid |-> $stable(result_data) && $stable(result_reg))
		else $error("result changed without pulse");
endmodule

bind xlau_unit xlau_chk u_chk (.clk, .sys_rst, .op_valid, .op_ready, .op_code, .first_source_reg,
	.destination_reg, .status_flags_in, .status_flags_out, .result_valid, .result_reg, .result_data);

// >>> xlau_dec_model.sv
/*
 * Decoder model: presents one operation and holds it until the unit takes it.
 * Assumes the unit samples requests on the rising clock edge.
 */
`timescale 1ns/1ps
module xlau_dec_model (
	// Handshake
	input  wire logic          clk,
	input  wire logic          op_ready,
	output logic               op_valid,
	// Operation fields
	output xlau_pkg::xlau_op_t op_code,
	output logic               use_immediate,
	output logic [8:0]         nine_bit_immediate,
	output logic [3:0]         first_source_reg,
	output logic [3:0]         second_source_reg,
	output logic [3:0]         destination_reg,
	output logic [4:0]         first_bit_select,
	output logic [4:0]         second_bit_select
);
	initial begin
		op_valid = 1'b0;
		op_code = xlau_pkg::XLAU_OP_XOR;
		{use_immediate, nine_bit_immediate, first_source_reg, second_source_reg} = '0;
		{destination_reg, first_bit_select, second_bit_select} = '0;
	end

	task automatic issue(input xlau_pkg::xlau_op_t c, input logic i, input logic [8:0] m,
		input logic [3:0] a, b, d, input logic [4:0] p, q);
		@(posedge clk);
		op_valid <= 1'b1;
		op_code <= c;
		{use_immediate, nine_bit_immediate, first_source_reg} <= {i, m, a};
		{second_source_reg, destination_reg, first_bit_select, second_bit_select} <= {b, d, p, q};
		do @(posedge clk); while (op_ready !== 1'b1);
		op_valid <= 1'b0;
		// Released fields other than op_code flip so a unit reading them late sees garbage
		{use_immediate, nine_bit_immediate, first_source_reg} <= ~{i, m, a};
		{second_source_reg, destination_reg, first_bit_select, second_bit_select} <= ~{b, d, p, q};
	endtask
endmodule

// >>> xlau_unit_bench.sv
/*
 * Self-checking bench for xlau_unit with a register model of its own.
 * Assumes registers start at zero and are seeded by immediate operations.
 */
`timescale 1ns/1ps
module xlau_unit_bench;
	logic               clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               op_valid, op_ready, use_immediate, result_valid;
	xlau_pkg::xlau_op_t op_code;
	logic [8:0]         nine_bit_immediate;
	logic [3:0]         first_source_reg, second_source_reg, destination_reg, result_reg;
	logic [4:0]         first_bit_select, second_bit_select, status_flags_out;
	logic [4:0]         status_flags_in = 5'h00;
	logic [31:0]        result_data;
	logic [31:0]        mdl [16] = '{default: 32'h0};
	int                 num_errors = 0;
	int                 total_checks = 0;
	int                 cycles = 0;

	always #20 clk = ~clk;

	xlau_unit uut (.clk, .sys_rst, .op_valid, .op_ready, .op_code, .use_immediate,
		.nine_bit_immediate, .first_source_reg, .second_source_reg, .destination_reg,
		.first_bit_select, .second_bit_select, .status_flags_in, .status_flags_out,
		.result_valid, .result_reg, .result_data);
	xlau_dec_model dec (.clk, .op_ready, .op_valid, .op_code, .use_immediate,
		.nine_bit_immediate, .first_source_reg, .second_source_reg, .destination_reg,
		.first_bit_select, .second_bit_select);

	task automatic summarize();
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// ****************************************
	// Expected result from the model, then issue and compare
	// ****************************************
	task automatic run(input xlau_pkg::xlau_op_t c, input logic i, input logic [8:0] m,
		input logic [3:0] a, b, d, input logic [4:0] p = 5'h00, q = 5'h00);
		logic [31:0] x, y, e;
		logic [3:0]  w;
		int          n;
		x = mdl[a];
		y = {{23{m[8]}}, m};
		if (c inside {xlau_pkg::XLAU_OP_XOR, xlau_pkg::XLAU_OP_XNOR, xlau_pkg::XLAU_OP_ACC_GE_U,
			xlau_pkg::XLAU_OP_ACC_LT_U})
			y = {23'h0, m};
		if (!i)
			y = mdl[b];
		w = d;
		e = mdl[d];
		case (c)
			xlau_pkg::XLAU_OP_XOR:      e = x ^ y;
			xlau_pkg::XLAU_OP_XNOR:     e = ~(x ^ y);
			xlau_pkg::XLAU_OP_BIT_XOR:  e = {31'h0, x[p] ^ mdl[b][q]};
			xlau_pkg::XLAU_OP_BIT_XNOR: e = {31'h0, ~(x[p] ^ mdl[b][q])};
			xlau_pkg::XLAU_OP_ACC_EQ:   e[0] ^= (x == y);
			xlau_pkg::XLAU_OP_ACC_NE:   e[0] ^= (x != y);
			xlau_pkg::XLAU_OP_ACC_GE:   e[0] ^= ($signed(x) >= $signed(y));
			xlau_pkg::XLAU_OP_ACC_GE_U: e[0] ^= (x >= y);
			xlau_pkg::XLAU_OP_ACC_LT:   e[0] ^= ($signed(x) < $signed(y));
			xlau_pkg::XLAU_OP_ACC_LT_U: e[0] ^= (x < y);
			default: begin
				e = x ^ mdl[b];
				w = a;
			end
		endcase
		@(posedge clk);
		status_flags_in <= 5'(c) ^ 5'h15;
		dec.issue(c, i, m, a, b, d, p, q);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (result_valid !== 1'b1 && n < 8);
		cmp(32'(result_valid), 32'h1);
		cmp(result_data, e);
		cmp(32'(result_reg), 32'(w));
		cmp(32'(status_flags_out), 32'(status_flags_in));
		mdl[w] = e;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_bitwise();
		run(xlau_pkg::XLAU_OP_XOR, 1'b1, 9'h1FF, 4'h0, 4'h0, 4'h1);
		run(xlau_pkg::XLAU_OP_XNOR, 1'b1, 9'h0A5, 4'h0, 4'h0, 4'h2);
		run(xlau_pkg::XLAU_OP_XOR, 1'b0, 9'h000, 4'h1, 4'h2, 4'h3);
		run(xlau_pkg::XLAU_OP_XNOR, 1'b0, 9'h000, 4'h3, 4'h1, 4'h4);
		run(xlau_pkg::XLAU_OP_XOR_SHORT, 1'b1, 9'h0FF, 4'h4, 4'h1, 4'h9);
		run(xlau_pkg::XLAU_OP_XOR, 1'b0, 9'h000, 4'h3, 4'h3, 4'h3);
	endtask

	task automatic t_bits();
		for (int k = 0; k < 32; k += 15) begin
			run(xlau_pkg::XLAU_OP_BIT_XOR, 1'b0, 9'h000, 4'h2, 4'h4, 4'h5, 5'(k), 5'(31 - k));
			run(xlau_pkg::XLAU_OP_BIT_XNOR, 1'b0, 9'h000, 4'h2, 4'h1, 4'h6, 5'(k), 5'(k + 1));
		end
	endtask

	task automatic t_accum();
		xlau_pkg::xlau_op_t c;
		for (int k = 5; k <= 10; k++) begin
			c = xlau_pkg::xlau_op_t'(k);
			run(c, 1'b1, 9'h100, 4'h2, 4'h0, 4'h2);
			run(c, 1'b1, 9'h1FF, 4'h1, 4'h0, 4'h4);
			run(c, 1'b0, 9'h000, 4'h2, 4'h1, 4'h4);
			run(c, 1'b0, 9'h000, 4'h1, 4'h1, 4'h7);
		end
	endtask

	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		cmp(result_data, 32'h0);
		cmp(32'(op_ready), 32'h1);
		t_bitwise();
		t_bits();
		t_accum();
		summarize();
	end
endmodule
